// >>> src/flag_bank_pkg.sv
// What this block does
// R1 - live flag registers follow each condition
// R2 - latched copy keeps set bits after condition
// R3 - latch clears on read-when-absent or power-on
// R4 - latch sets only on live rising edge
// R5 - host rereads latched register to confirm clear; the bench rereads only the channel a latched register
// R6 - one means fault, bits are read-only
// R7 - channel a off bit until power-on request
// R8 - channel a power-good fault ors its causes
// R9 - channel a bits five to one layout
// R10 - channel a reference range error, no response
// R11 - channel b off bit until power-on request
// R12 - channel b power-good fault ors its causes
// R13 - channel b bits five to zero layout
// R14 - shared bit six supply overvoltage, seven reserved
// R15 - shared bits five four three layout
// R16 - shared bit two line sense low
// R17 - shared bit one crc error, immediate shutdown
// R18 - shared bit zero external flag input
// R19 - read returns old value, set beats clear
package flag_bank_pkg;
    // ----------------------------------------
    // register map (index, byte address = 4 * index)
    // ----------------------------------------
    localparam logic [15:0] idx_chan_a_live = 16'hfec0;
    localparam logic [15:0] idx_chan_b_live = 16'hfec1;
    localparam logic [15:0] idx_shared_live = 16'hfec2;
    localparam logic [15:0] idx_chan_a_latched = 16'hfec5;
    localparam logic [15:0] idx_chan_b_latched = 16'hfec6;
    localparam logic [15:0] idx_shared_latched = 16'hfec7;
    localparam logic [15:0] idx_irq_status = 16'hfed0;
    localparam logic [15:0] idx_irq_mask = 16'hfed1;
    localparam logic [15:0] idx_pg_option = 16'hfed2;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int bit_ch_off = 7;
    localparam int bit_ch_pg = 6;
    localparam int bit_sh_supply_overvoltage = 6;
    localparam int bit_sh_crc = 1;
    // power-good option bits
    localparam int bit_opt_line_a = 0;
    localparam int bit_opt_warn_a = 1;
    localparam int bit_opt_line_b = 2;
    localparam int bit_opt_warn_b = 3;
    // irq status layout: one bit per latched register
    localparam int bit_irq_a = 0;
    localparam int bit_irq_b = 1;
    localparam int bit_irq_sh = 2;
    localparam logic [7:0] reset_flags = 8'h00;
    localparam logic [3:0] reset_pg_option = 4'h0;
    localparam logic [2:0] reset_irq = 3'h0;
    localparam logic [31:0] unmapped_data = 32'h00000000;
    localparam logic [7:0] shared_valid_mask = 8'h7f;

    // per-channel condition inputs
    typedef struct packed {
        logic undervoltage;
        logic overvoltage;
        logic primary_overcurrent;
        logic secondary_overcurrent;
        logic light_load;
        logic ref_range_error;
        logic softstart_filter_active;
        logic power_off;
        logic power_on_request;
    } chan_cond_t;

    // shared condition inputs
    typedef struct packed {
        logic supply_overvoltage;
        logic shared_overcurrent;
        logic zone_two_overtemp;
        logic zone_one_overtemp;
        logic line_sense_low;
        logic crc_error;
        logic zone_one_temp_warning;
        logic zone_two_temp_warning;
        logic power_on_request;
    } shared_cond_t;
endpackage : flag_bank_pkg

// >>> src/flag_latch.sv
`timescale 1ns/1ns
// one latched flag register fed by its live value
module flag_latch (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] live,
    input wire logic read_clear,
    input wire logic power_on_clear,
    output logic [7:0] latched,
    output logic rise_any
);
    logic [7:0] live_prev;
    logic [7:0] rise;

    // edge detect on live flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            live_prev <= flag_bank_pkg::reset_flags;
        end else begin
            live_prev <= live;
        end
    end

    assign rise = live & ~live_prev; // [R4]
    assign rise_any = |rise;

    // per bit: set by rising edge, cleared by read when absent or power-on
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    latched[i] <= 1'b0;
                end else if (rise[i]) begin
                    latched[i] <= 1'b1; // [R2] [R4] [R19]
                end else if (power_on_clear || (read_clear && !live[i])) begin
                    latched[i] <= 1'b0; // [R3] [R19]
                end
            end
        end
    endgenerate

    AST_RISE_SETS: assert property (@(posedge mclk) disable iff (rst) // [R4]
        rise[0] |=> latched[0]) else $error("rising live flag did not latch");
    AST_HOLD_NO_CLEAR: assert property (@(posedge mclk) disable iff (rst) // [R2] [R3]
        latched[1] && !read_clear && !power_on_clear |=> latched[1])
        else $error("latched flag lost without clear");
    AST_HIGH_NO_RESET: assert property (@(posedge mclk) disable iff (rst) // [R4]
        live[2] && $past(live[2]) && !latched[2] |=> !latched[2])
        else $error("steady live flag set latch");
endmodule : flag_latch

// >>> src/fault_flag_status_bank.sv
`timescale 1ns/1ns
module fault_flag_status_bank (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire flag_bank_pkg::chan_cond_t chan_a,
    input wire flag_bank_pkg::chan_cond_t chan_b,
    input wire flag_bank_pkg::shared_cond_t shared,
    input wire logic ext_flag_sync_in_pin,
    output logic chan_a_power_good_fault,
    output logic chan_b_power_good_fault,
    output logic crc_shutdown,
    output logic irq
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    flag_bank_pkg::chan_cond_t a_meta, a_sync, b_meta, b_sync;
    flag_bank_pkg::shared_cond_t s_meta, s_sync;
    logic ext_meta, external_flag_input;

    // two stages on every asynchronous condition
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_meta <= '0;
            a_sync <= '0;
            b_meta <= '0;
            b_sync <= '0;
            s_meta <= '0;
            s_sync <= '0;
            ext_meta <= 1'b0;
            external_flag_input <= 1'b0;
        end else begin
            a_meta <= chan_a;
            a_sync <= a_meta;
            b_meta <= chan_b;
            b_sync <= b_meta;
            s_meta <= shared;
            s_sync <= s_meta;
            ext_meta <= ext_flag_sync_in_pin;
            external_flag_input <= ext_meta;
        end
    end

    // ----------------------------------------
    // channel off state
    // ----------------------------------------
    logic a_off, b_off;

    // channel a off bit: set on shutdown, kept until power-on request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_off <= 1'b0;
        end else if (a_sync.power_on_request) begin
            a_off <= 1'b0; // [R7]
        end else if (a_sync.power_off || s_sync.crc_error) begin
            a_off <= 1'b1; // [R7] [R17]
        end
    end

    // channel b off bit: set on shutdown, kept until power-on request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            b_off <= 1'b0;
        end else if (b_sync.power_on_request) begin
            b_off <= 1'b0; // [R11]
        end else if (b_sync.power_off || s_sync.crc_error) begin
            b_off <= 1'b1; // [R11] [R17]
        end
    end

    // ----------------------------------------
    // live flag registers
    // ----------------------------------------
    logic [3:0] pg_option;
    logic [7:0] a_live, b_live, s_live;
    logic a_pg, b_pg;

    // power-good fault terms, optional line sense and warnings
    always_comb begin
        a_pg = a_sync.undervoltage | a_off | s_sync.crc_error | a_sync.softstart_filter_active
            | (pg_option[flag_bank_pkg::bit_opt_line_a] & s_sync.line_sense_low)
            | (pg_option[flag_bank_pkg::bit_opt_warn_a] & s_sync.zone_one_temp_warning); // [R8]
        b_pg = b_sync.undervoltage | b_off | s_sync.crc_error | b_sync.softstart_filter_active
            | (pg_option[flag_bank_pkg::bit_opt_line_b] & s_sync.line_sense_low)
            | (pg_option[flag_bank_pkg::bit_opt_warn_b] & s_sync.zone_two_temp_warning); // [R12]
    end

    // live registers follow the conditions, one means fault
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_live <= flag_bank_pkg::reset_flags;
            b_live <= flag_bank_pkg::reset_flags;
            s_live <= flag_bank_pkg::reset_flags;
        end else begin
            a_live <= {a_off, a_pg, a_sync.primary_overcurrent, a_sync.secondary_overcurrent,
                       a_sync.undervoltage, a_sync.overvoltage, a_sync.light_load,
                       a_sync.ref_range_error}; // [R1] [R6] [R7] [R8] [R9] [R10]
            b_live <= {b_off, b_pg, b_sync.primary_overcurrent, b_sync.secondary_overcurrent,
                       b_sync.undervoltage, b_sync.overvoltage, b_sync.light_load,
                       b_sync.ref_range_error}; // [R1] [R6] [R11] [R12] [R13]
            s_live <= {1'b0, s_sync.supply_overvoltage, s_sync.shared_overcurrent,
                       s_sync.zone_two_overtemp, s_sync.zone_one_overtemp,
                       s_sync.line_sense_low, s_sync.crc_error,
                       external_flag_input}; // [R1] [R14] [R15] [R16] [R17] [R18]
        end
    end

    // ----------------------------------------
    // outputs to pins
    // ----------------------------------------
    // pin faults from live power-good bits; crc stops both channels at once
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chan_a_power_good_fault <= 1'b0;
            chan_b_power_good_fault <= 1'b0;
            crc_shutdown <= 1'b0;
        end else begin
            chan_a_power_good_fault <= a_live[flag_bank_pkg::bit_ch_pg]; // [R8]
            chan_b_power_good_fault <= b_live[flag_bank_pkg::bit_ch_pg]; // [R12]
            crc_shutdown <= s_live[flag_bank_pkg::bit_sh_crc]; // [R17]
        end
    end

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic [15:0] idx;
    logic req, rd_req;
    logic rd_a_lat, rd_b_lat, rd_s_lat, rd_status;
    logic wr_commit;

    // a request is taken while ack is low; a write lands on the edge that shows ack
    assign idx = wb_adr_i[17:2];
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_req = req & ~wb_we_i;
    assign wr_commit = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign rd_a_lat = rd_req && idx == flag_bank_pkg::idx_chan_a_latched;
    assign rd_b_lat = rd_req && idx == flag_bank_pkg::idx_chan_b_latched;
    assign rd_s_lat = rd_req && idx == flag_bank_pkg::idx_shared_latched;
    assign rd_status = rd_req && idx == flag_bank_pkg::idx_irq_status;

    // ----------------------------------------
    // latched registers
    // ----------------------------------------
    logic [7:0] a_lat, b_lat, s_lat;
    logic a_rise, b_rise, s_rise;
    logic pon_a, pon_b, pon_s;

    // each latch bank clears on its own power-on request
    assign pon_a = a_sync.power_on_request;
    assign pon_b = b_sync.power_on_request;
    assign pon_s = s_sync.power_on_request;

    flag_latch u_lat_a (
        .mclk(mclk),
        .rst(rst),
        .live(a_live),
        .read_clear(rd_a_lat),
        .power_on_clear(pon_a),
        .latched(a_lat),
        .rise_any(a_rise)
    );

    flag_latch u_lat_b (
        .mclk(mclk),
        .rst(rst),
        .live(b_live),
        .read_clear(rd_b_lat),
        .power_on_clear(pon_b),
        .latched(b_lat),
        .rise_any(b_rise)
    );

    flag_latch u_lat_s (
        .mclk(mclk),
        .rst(rst),
        .live(s_live),
        .read_clear(rd_s_lat),
        .power_on_clear(pon_s),
        .latched(s_lat),
        .rise_any(s_rise)
    );

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [2:0] irq_status, irq_mask;
    logic [2:0] irq_set;

    // any new latch event raises its status bit
    assign irq_set = {s_rise, b_rise, a_rise};

    // sticky status, read clears, new event wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= flag_bank_pkg::reset_irq;
        end else if (rd_status) begin
            irq_status <= irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    // software-written interrupt mask
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask <= flag_bank_pkg::reset_irq;
        end else if (wr_commit && idx == flag_bank_pkg::idx_irq_mask) begin
            irq_mask <= wb_dat_i[2:0];
        end
    end

    // software-written power-good options
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pg_option <= flag_bank_pkg::reset_pg_option;
        end else if (wr_commit && idx == flag_bank_pkg::idx_pg_option) begin
            pg_option <= wb_dat_i[3:0];
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // read data and acknowledge
    // ----------------------------------------
    logic [31:0] next_rdata;

    // value before any clear is returned; flags read-only, writes ignored
    always_comb begin
        case (idx)
            flag_bank_pkg::idx_chan_a_live: next_rdata = {24'h000000, a_live};
            flag_bank_pkg::idx_chan_b_live: next_rdata = {24'h000000, b_live};
            flag_bank_pkg::idx_shared_live: next_rdata = {24'h000000, s_live};
            flag_bank_pkg::idx_chan_a_latched: next_rdata = {24'h000000, a_lat}; // [R19]
            flag_bank_pkg::idx_chan_b_latched: next_rdata = {24'h000000, b_lat}; // [R19]
            flag_bank_pkg::idx_shared_latched: next_rdata = {24'h000000,
                s_lat & flag_bank_pkg::shared_valid_mask}; // [R14]
            flag_bank_pkg::idx_irq_status: next_rdata = {29'h0, irq_status};
            flag_bank_pkg::idx_irq_mask: next_rdata = {29'h0, irq_mask};
            flag_bank_pkg::idx_pg_option: next_rdata = {28'h0000000, pg_option};
            default: next_rdata = flag_bank_pkg::unmapped_data;
        endcase
    end

    // one-cycle ack for every access, mapped or not
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // read data captured at the taking edge, held until the next read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= flag_bank_pkg::unmapped_data;
        end else if (rd_req) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // channel off state and power-good pins
    AST_A_OFF_HOLD: assert property (@(posedge mclk) disable iff (rst) // [R7]
        a_off && !a_sync.power_on_request |=> a_off) else $error("chan a off dropped early");
    AST_B_OFF_HOLD: assert property (@(posedge mclk) disable iff (rst) // [R11]
        b_off && !b_sync.power_on_request |=> b_off) else $error("chan b off dropped early");
    AST_CRC_OFF_A: assert property (@(posedge mclk) disable iff (rst) // [R17]
        s_sync.crc_error && !a_sync.power_on_request |=> a_off) else $error("crc kept chan a on");
    AST_CRC_OFF_B: assert property (@(posedge mclk) disable iff (rst) // [R17]
        s_sync.crc_error && !b_sync.power_on_request |=> b_off) else $error("crc kept chan b on");
    AST_A_PG_PIN: assert property (@(posedge mclk) disable iff (rst) // [R8]
        a_sync.undervoltage |-> ##2 chan_a_power_good_fault) else $error("chan a pg fault missed");
    AST_A_OFF_PIN: assert property (@(posedge mclk) disable iff (rst) // [R8]
        a_off |-> ##2 chan_a_power_good_fault) else $error("chan a off pg fault missed");
    AST_B_PG_PIN: assert property (@(posedge mclk) disable iff (rst) // [R12]
        b_off |-> ##2 chan_b_power_good_fault) else $error("chan b pg fault missed");
    AST_B_UV_PIN: assert property (@(posedge mclk) disable iff (rst) // [R12]
        b_sync.undervoltage |-> ##2 chan_b_power_good_fault) else $error("chan b uv pg fault missed");
    AST_CRC_SHUT: assert property (@(posedge mclk) disable iff (rst) // [R17]
        s_sync.crc_error |-> ##2 crc_shutdown) else $error("crc shutdown missed");
    // live registers follow their conditions
    AST_LIVE_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R1] [R9]
        ##1 a_live[5] == $past(a_sync.primary_overcurrent)) else $error("live flag not following");
    AST_A_LIGHT_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R9]
        ##1 a_live[1] == $past(a_sync.light_load)) else $error("chan a light load wrong");
    AST_A_REF_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R10]
        ##1 a_live[0] == $past(a_sync.ref_range_error)) else $error("chan a range error wrong");
    AST_B_LIVE_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R1] [R13]
        ##1 b_live[5] == $past(b_sync.primary_overcurrent)) else $error("chan b overcurrent wrong");
    AST_B_REF_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R13]
        ##1 b_live[0] == $past(b_sync.ref_range_error)) else $error("chan b range error wrong");
    AST_SH_OV_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R14]
        ##1 s_live[6] == $past(s_sync.supply_overvoltage)) else $error("supply overvoltage wrong");
    AST_SH_OC_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R15]
        ##1 s_live[5] == $past(s_sync.shared_overcurrent)) else $error("shared overcurrent wrong");
    AST_LINE_FOLLOW: assert property (@(posedge mclk) disable iff (rst) // [R16]
        ##1 s_live[2] == $past(s_sync.line_sense_low)) else $error("line sense flag wrong");
    AST_SH_RSVD: assert property (@(posedge mclk) disable iff (rst) // [R14]
        !s_live[7]) else $error("reserved shared bit set");
    AST_EXT_FLAG: assert property (@(posedge mclk) disable iff (rst) // [R18]
        ext_flag_sync_in_pin [*4] |-> s_live[0]) else $error("external flag not shown");
    // latched clears
    AST_READ_CLEAR: assert property (@(posedge mclk) disable iff (rst) // [R3]
        rd_a_lat && !a_live[3] && !a_rise |=> !a_lat[3]) else $error("read did not clear latch");
    AST_PON_CLEAR: assert property (@(posedge mclk) disable iff (rst) // [R3]
        pon_s && !s_rise |=> s_lat == 8'h00) else $error("power-on did not clear latch");
    // interrupt and bus
    AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (rst)
        (irq_status & irq_mask) != 3'h0 |=> irq) else $error("irq missing");
    AST_IRQ_STICKY: assert property (@(posedge mclk) disable iff (rst)
        irq_status[0] && !rd_status |=> irq_status[0]) else $error("irq status lost");
    AST_ACK_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
        req |=> wb_ack_o) else $error("request not acked");
    AST_ACK_ONE: assert property (@(posedge mclk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    AST_DAT_HELD: assert property (@(posedge mclk) disable iff (rst)
        !rd_req |=> $stable(wb_dat_o)) else $error("read data changed without read");

    // main scenarios
    COV_READ_LATCH: cover property (@(posedge mclk) disable iff (rst) rd_a_lat && a_lat != 8'h00);
    COV_IRQ: cover property (@(posedge mclk) disable iff (rst) irq);
    COV_SET_CLEAR: cover property (@(posedge mclk) disable iff (rst) rd_b_lat && b_rise);
    COV_PON: cover property (@(posedge mclk) disable iff (rst) pon_a && a_lat != 8'h00);
    COV_CRC_STOP: cover property (@(posedge mclk) disable iff (rst) s_sync.crc_error && a_off && b_off);
endmodule : fault_flag_status_bank

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb;
    // ----------------------------------------
    // stimulus and reference state
    // ----------------------------------------
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] wb_adr = 32'h00000000;
    logic [31:0] wb_dat = 32'h00000000;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [3:0] wb_sel = 4'h0;
    logic [8:0] ca_v = 9'h000;
    logic [8:0] cb_v = 9'h000;
    logic [8:0] sh_v = 9'h000;
    logic ext = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, pg_a, pg_b, crc_shutdown, irq;
    int num_errors = 0;
    int cmp_count = 0;
    logic off_a = 1'b0;
    logic off_b = 1'b0;
    logic [7:0] la = 8'h00, lb = 8'h00, ls = 8'h00;
    logic [7:0] pa = 8'h00, pb = 8'h00, ps = 8'h00;
    logic [2:0] irq_st = 3'h0, mask = 3'h0;
    logic [3:0] opt = 4'h0;
    logic [31:0] d, wd;
    int r;

    // free-running clock
    always #4 mclk = ~mclk;

    fault_flag_status_bank i_dut (
        .mclk(mclk),
        .rst(rst),
        .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we),
        .wb_sel_i(wb_sel),
        .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb),
        .wb_ack_o(wb_ack_o),
        .chan_a(flag_bank_pkg::chan_cond_t'(ca_v)),
        .chan_b(flag_bank_pkg::chan_cond_t'(cb_v)),
        .shared(flag_bank_pkg::shared_cond_t'(sh_v)),
        .ext_flag_sync_in_pin(ext),
        .chan_a_power_good_fault(pg_a),
        .chan_b_power_good_fault(pg_b),
        .crc_shutdown(crc_shutdown),
        .irq(irq)
    );

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    // channel live byte: off, power-good fault, then the five cause bits and range error
    function automatic logic [7:0] chan_live(logic [8:0] v, logic off, logic crc, logic line, logic warn);
        flag_bank_pkg::chan_cond_t c;
        c = flag_bank_pkg::chan_cond_t'(v);
        return {off, c.undervoltage | off | crc | c.softstart_filter_active | line | warn, c.primary_overcurrent,
            c.secondary_overcurrent, c.undervoltage, c.overvoltage, c.light_load, c.ref_range_error};
    endfunction : chan_live

    // advance the reference once the inputs have settled
    task automatic model_update;
        logic [7:0] na, nb, ns;
        off_a = ca_v[0] ? 1'b0 : (off_a | ca_v[1] | sh_v[3]);
        off_b = cb_v[0] ? 1'b0 : (off_b | cb_v[1] | sh_v[3]);
        na = chan_live(ca_v, off_a, sh_v[3], opt[0] & sh_v[4], opt[1] & sh_v[2]);
        nb = chan_live(cb_v, off_b, sh_v[3], opt[2] & sh_v[4], opt[3] & sh_v[1]);
        ns = {1'b0, sh_v[8:3], ext};
        irq_st = irq_st | {|(ns & ~ps), |(nb & ~pb), |(na & ~pa)};
        la = ca_v[0] ? 8'h00 : (la | (na & ~pa));
        lb = cb_v[0] ? 8'h00 : (lb | (nb & ~pb));
        ls = sh_v[0] ? 8'h00 : (ls | (ns & ~ps));
        pa = na;
        pb = nb;
        ps = ns;
    endtask : model_update

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [15:0] idx, input logic [31:0] wdat, output logic [31:0] rd);
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hf;
        wb_adr <= {14'h0000, idx, 2'b00};
        wb_dat <= wdat;
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_sel <= 4'h0;
    endtask : bus

    task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, idx, 32'h00000000, v);
        chk(nm, exp, v);
    endtask : rd_chk

    task automatic settle;
        repeat (8) @(posedge mclk);
    endtask : settle

    // pins, then the live, latched and irq status registers; reads clear the sticky copies
    task automatic check_all;
        chk("irq", {31'h0, |(irq_st & mask)}, {31'h0, irq});
        chk("pg_a", {31'h0, pa[6]}, {31'h0, pg_a});
        chk("pg_b", {31'h0, pb[6]}, {31'h0, pg_b});
        chk("crc_shutdown", {31'h0, sh_v[3]}, {31'h0, crc_shutdown});
        rd_chk("live_a", flag_bank_pkg::idx_chan_a_live, {24'h0, pa});
        rd_chk("live_b", flag_bank_pkg::idx_chan_b_live, {24'h0, pb});
        rd_chk("live_sh", flag_bank_pkg::idx_shared_live, {24'h0, ps});
        rd_chk("lat_a", flag_bank_pkg::idx_chan_a_latched, {24'h0, la});
        la = la & pa;
        rd_chk("lat_a_again", flag_bank_pkg::idx_chan_a_latched, {24'h0, la});
        rd_chk("lat_b", flag_bank_pkg::idx_chan_b_latched, {24'h0, lb});
        lb = lb & pb;
        rd_chk("lat_sh", flag_bank_pkg::idx_shared_latched, {24'h0, ls});
        ls = ls & ps;
        rd_chk("irq_status", flag_bank_pkg::idx_irq_status, {29'h0, irq_st});
        irq_st = 3'h0;
    endtask : check_all

    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h29bd));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        settle();
        rd_chk("irq_mask", flag_bank_pkg::idx_irq_mask, 32'h00000000);
        rd_chk("pg_option", flag_bank_pkg::idx_pg_option, 32'h00000000);
        rd_chk("unmapped", 16'hfeff, flag_bank_pkg::unmapped_data);
        check_all();
        for (int i = 0; i < 150; i++) begin
            r = $urandom % 4;
            wd = $urandom;
            bus(1'b1, flag_bank_pkg::idx_irq_mask, wd, d);
            mask = wd[2:0];
            wd = $urandom;
            bus(1'b1, flag_bank_pkg::idx_pg_option, wd, d);
            opt = wd[3:0];
            rd_chk("pg_option", flag_bank_pkg::idx_pg_option, {28'h0, opt});
            bus(1'b1, flag_bank_pkg::idx_chan_a_latched, 32'h000000ff, d);
            bus(1'b1, flag_bank_pkg::idx_shared_live, 32'h000000ff, d);
            settle();
            model_update();
            if (r == 0) begin
                ca_v <= ca_v | 9'($urandom & 32'h1);
                cb_v <= cb_v | 9'($urandom & 32'h1);
                sh_v <= sh_v | 9'($urandom & 32'h1);
                settle();
                model_update();
                check_all();
                ca_v <= ca_v & 9'h1fe;
                cb_v <= cb_v & 9'h1fe;
                sh_v <= sh_v & 9'h1fe;
            end else if (r == 1) begin
                ca_v <= (ca_v & 9'h1fc) | 9'($urandom & 32'h2);
                cb_v <= (cb_v & 9'h1fc) | 9'($urandom & 32'h2);
                sh_v <= (sh_v & 9'h1f6) | 9'($urandom & 32'h8);
            end else begin
                ca_v <= (ca_v & 9'h003) | 9'($urandom & 32'h1fc);
                cb_v <= (cb_v & 9'h003) | 9'($urandom & 32'h1fc);
                sh_v <= (sh_v & 9'h009) | 9'($urandom & 32'h1f6);
                ext <= 1'($urandom);
            end
            settle();
            model_update();
            check_all();
        end
        wrap_up();
    end

    // watchdog against a bus that never answers
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        wrap_up();
    end
endmodule : tb
